/* File: cled_config_link_error_detect.sv */
// The register offsets and the address-and-strobe port are this design's own decisions.
`default_nettype none
// Operation
// - config errors logged only when config reporting on
// - bad mask route write gives 0x50, no-route
// - mask number into domain table gives 0x50
// - bad mask in mask-port or select gives 0x50
// - write-verify touching domain table gives 0x50
// - reading invalid mask value gives 0x50
// - bad port route write gives 0x53, no-route
// - bad egress port in mask-port gives 0x53
// - nonexistent trace port gives 0x53
// - force-local route write gives 0x54, no-route
// - illegal route read gives 0x55, returns FF
// - invalid port bit gives 0x56, write proceeds
// - input/output port selects get same check
// - lane sync loss codes 0x60..0x63, quad gated
// - 4x alignment loss gives 0x64, quad gated
// - serdes gated by quad, link by port
// - bad char or symbol gives 0x70
// - unaligned delimiter gives 0x71, port gated
// - 4x delimiter errors go to port 0
// - bad outstanding ack id gives 0x72
// - each log entry carries source and code
// - one shared log, arbitrated between sources
module cled_config_link_error_detect
  import cled_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [DATA_W-1:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [DATA_W-1:0] regRdata,
  input wire logic [LANE_CNT-1:0] laneSyncLost,
  input wire logic alignLost,
  input wire logic [LANE_CNT-1:0] charErr,
  input wire logic [LANE_CNT-1:0] delimErr,
  input wire logic [LANE_CNT-1:0] ackIdErr,
  input wire logic logAccept,
  output logic logValid,
  output logic [5:0] logSource,
  output logic [7:0] logCode
);

  ////////////////////////////////////////////////////////////////////////
  // decode helpers
  function automatic logic portOk(input logic [7:0] v);
    return v < 8'(PORT_CNT);
  endfunction

  function automatic logic maskIdxOk(input logic [7:0] v);
    return v < 8'(MASK_CNT);
  endfunction

  // code for a value written into a route or domain entry
  function automatic logic [7:0] routeCheck(input logic [7:0] v, input logic dom);
    if (v == VAL_NO_ROUTE) begin
      return CODE_NONE;
    end
    if (v == VAL_FORCE_LOCAL) begin
      return CODE_FORCE_LOCAL;
    end
    if (v >= VAL_MASK_BASE && v <= VAL_MASK_LAST) begin
      // domain table holds no masks at all
      return (dom || !maskIdxOk(v - VAL_MASK_BASE)) ? CODE_MASK_CFG : CODE_NONE;
    end
    return portOk(v) ? CODE_NONE : CODE_PORT_CFG;
  endfunction

  // reporting enable chosen by code group
  function automatic logic reportOn(input logic [7:0] code, input logic [CTRL_W-1:0] c);
    case (code[7:4])
      GRP_CFG: return c[CTRL_CFG_EN];
      GRP_SERDES: return c[CTRL_QUAD_EN];
      GRP_LINK: return c[CTRL_PORT_EN];
      default: return 1'b0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // configuration state
  logic [CTRL_W-1:0] ctrl_q; // reporting enables and quad mode
  logic [ENTRY_IDX_W:0] rtIndex_q; // entry index, msb selects domain table
  logic [7:0] routeTbl_q [ENTRY_CNT];
  logic [7:0] domTbl_q [ENTRY_CNT];
  logic [PORT_CNT-1:0] mcMask_q [MASK_CNT];
  logic [7:0] assocSel_q; // kept even when invalid, flagged on use
  logic [PORT_CNT-1:0] inPorts_q;
  logic [PORT_CNT-1:0] outPorts_q;
  logic [7:0] trace_q;
  logic [DATA_W-1:0] regRdata_q;
  logic [DATA_W-1:0] rdNext;

  logic wrHit;
  logic rdHit;
  logic [7:0] wVal;
  logic [7:0] wPort;
  logic [ENTRY_IDX_W-1:0] idx;
  logic dom;
  logic [7:0] entryVal;
  logic [7:0] cfgCode; // raw config error code this cycle
  logic [PORT_CNT-1:0] validBits;

  assign wrHit = regWr;
  assign rdHit = regRd;
  assign wVal = regWdata[7:0];
  assign wPort = regWdata[MP_PORT_LSB +: 8];
  assign idx = rtIndex_q[ENTRY_IDX_W-1:0];
  assign dom = rtIndex_q[RT_DOM_BIT];
  assign entryVal = dom ? domTbl_q[idx] : routeTbl_q[idx];
  assign validBits = regWdata[PORT_CNT-1:0];

  ////////////////////////////////////////////////////////////////////////
  // config error detection on each bus access
  always_comb begin
    cfgCode = CODE_NONE;
    if (wrHit) begin
      case (regAddr)
        REG_RT_DATA: cfgCode = routeCheck(wVal, dom);
        REG_MC_MASK_PORT: begin
          if (!maskIdxOk(wVal)) begin
            cfgCode = CODE_MASK_CFG;
          end else if (!portOk(wPort)) begin
            cfgCode = CODE_PORT_CFG;
          end
        end
        REG_MC_ASSOC_SEL: begin
          if (!maskIdxOk(wVal)) begin
            cfgCode = CODE_MASK_CFG;
          end
        end
        REG_MC_ASSOC_OP: begin
          // verify would land in the mask-less domain table
          if (regWdata[1:0] == OP_WRITE_VERIFY && regWdata[OP_DOM_BIT]) begin
            cfgCode = CODE_MASK_CFG;
          end
        end
        REG_MC_VEC: begin
          if (!maskIdxOk(assocSel_q)) begin
            cfgCode = CODE_MASK_CFG;
          end else if (|regWdata[DATA_W-1:PORT_CNT]) begin
            cfgCode = CODE_BIT_CFG;
          end
        end
        REG_IN_PORTS, REG_OUT_PORTS: begin
          if (|regWdata[DATA_W-1:PORT_CNT]) begin
            cfgCode = CODE_BIT_CFG;
          end
        end
        REG_TRACE: begin
          if (!portOk(wVal)) begin
            cfgCode = CODE_PORT_CFG;
          end
        end
        default: cfgCode = CODE_NONE;
      endcase
    end else if (rdHit) begin
      if (regAddr == REG_RT_DATA && routeCheck(entryVal, dom) != CODE_NONE) begin
        cfgCode = CODE_RT_READ;
      end else if (regAddr == REG_MC_VEC && !maskIdxOk(assocSel_q)) begin
        cfgCode = CODE_MASK_CFG;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register writes
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_q <= '0;
      rtIndex_q <= '0;
      assocSel_q <= '0;
      inPorts_q <= '0;
      outPorts_q <= '0;
      trace_q <= '0;
    end else if (wrHit) begin
      case (regAddr)
        REG_CTRL: ctrl_q <= regWdata[CTRL_W-1:0];
        REG_RT_INDEX: rtIndex_q <= regWdata[ENTRY_IDX_W:0];
        REG_MC_ASSOC_SEL: assocSel_q <= wVal;
        // invalid high bits dropped, valid ports still updated
        REG_IN_PORTS: inPorts_q <= validBits;
        REG_OUT_PORTS: outPorts_q <= validBits;
        REG_TRACE: begin
          if (portOk(wVal)) begin
            trace_q <= wVal;
          end
        end
        default: ;
      endcase
    end
  end

  // route and domain tables, bad values replaced with no-route
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < ENTRY_CNT; i++) begin
        routeTbl_q[i] <= VAL_NO_ROUTE;
        domTbl_q[i] <= VAL_NO_ROUTE;
      end
    end else if (wrHit && regAddr == REG_RT_DATA) begin
      if (dom) begin
        domTbl_q[idx] <= (routeCheck(wVal, 1'b1) == CODE_NONE) ? wVal : VAL_NO_ROUTE;
      end else begin
        routeTbl_q[idx] <= (routeCheck(wVal, 1'b0) == CODE_NONE) ? wVal : VAL_NO_ROUTE;
      end
    end
  end

  // multicast masks: per-port add/remove or whole vector
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < MASK_CNT; i++) begin
        mcMask_q[i] <= '0;
      end
    end else if (wrHit && regAddr == REG_MC_MASK_PORT) begin
      if (maskIdxOk(wVal) && portOk(wPort)) begin
        mcMask_q[wVal[MASK_IDX_W-1:0]][wPort[3:0]] <= regWdata[MP_ADD_BIT];
      end
    end else if (wrHit && regAddr == REG_MC_VEC && maskIdxOk(assocSel_q)) begin
      mcMask_q[assocSel_q[MASK_IDX_W-1:0]] <= validBits;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read data: valid only in the cycle after the strobe
  logic [SLOT_CNT-1:0] pend_q;
  logic [SYNC_CNT-1:0] lvl_q;

  always_comb begin
    rdNext = '0;
    case (regAddr)
      REG_CTRL: rdNext[CTRL_W-1:0] = ctrl_q;
      REG_RT_INDEX: rdNext[ENTRY_IDX_W:0] = rtIndex_q;
      // illegal entry reads back as all ones
      REG_RT_DATA: rdNext[7:0] = (routeCheck(entryVal, dom) != CODE_NONE) ? VAL_READ_FAIL : entryVal;
      REG_MC_ASSOC_SEL: rdNext[7:0] = assocSel_q;
      REG_MC_VEC: rdNext[PORT_CNT-1:0] = maskIdxOk(assocSel_q) ? mcMask_q[assocSel_q[MASK_IDX_W-1:0]] : '0;
      REG_IN_PORTS: rdNext[PORT_CNT-1:0] = inPorts_q;
      REG_OUT_PORTS: rdNext[PORT_CNT-1:0] = outPorts_q;
      REG_TRACE: rdNext[7:0] = trace_q;
      REG_STATUS: begin
        rdNext[SLOT_CNT-1:0] = pend_q;
        rdNext[STAT_LANE_LSB +: SYNC_CNT] = lvl_q;
      end
      default: rdNext = '0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      regRdata_q <= '0;
    end else begin
      regRdata_q <= rdHit ? rdNext : '0;
    end
  end
  assign regRdata = regRdata_q;

  ////////////////////////////////////////////////////////////////////////
  // serdes status pins: three stages, level taken once stages 2 and 3 agree
  logic [SYNC_CNT-1:0] s1_q;
  logic [SYNC_CNT-1:0] s2_q;
  logic [SYNC_CNT-1:0] s3_q;
  logic [SYNC_CNT-1:0] lvl_d;
  logic [SYNC_CNT-1:0] rise;

  always_ff @(posedge clk) begin
    if (rst) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      lvl_q <= '0;
    end else begin
      s1_q <= {alignLost, laneSyncLost};
      s2_q <= s1_q;
      s3_q <= s2_q;
      lvl_q <= lvl_d;
    end
  end
  // hold level while the two late stages disagree
  assign lvl_d = (s2_q & s3_q) | (lvl_q & (s2_q | s3_q));
  assign rise = lvl_d & ~lvl_q;

  ////////////////////////////////////////////////////////////////////////
  // event vector per slot
  logic [SLOT_CNT-1:0] evtRaw;
  logic [SLOT_CNT-1:0] evt;
  logic [7:0] evtCode [SLOT_CNT];
  logic [5:0] evtSrc [SLOT_CNT];
  logic mode4x;
  assign mode4x = ctrl_q[CTRL_MODE4X];

  assign evtRaw[SL_CFG] = (cfgCode != CODE_NONE);
  assign evtCode[SL_CFG] = cfgCode;
  assign evtSrc[SL_CFG] = SRC_CFG;
  assign evtRaw[SL_ALIGN] = rise[LANE_CNT] && mode4x;
  assign evtCode[SL_ALIGN] = CODE_ALIGN;
  assign evtSrc[SL_ALIGN] = SRC_PORT[0];

  genvar g;
  generate
    for (g = 0; g < LANE_CNT; g++) begin : gLane
      assign evtRaw[SL_SYNC+g] = rise[g];
      assign evtCode[SL_SYNC+g] = CODE_SYNC_LANE0 + 8'(g);
      assign evtSrc[SL_SYNC+g] = SRC_PORT[g];
      assign evtRaw[SL_CHAR+g] = charErr[g];
      assign evtCode[SL_CHAR+g] = CODE_CHAR;
      assign evtSrc[SL_CHAR+g] = SRC_PORT[g];
      // 4x quad folds every lane's delimiter error onto port 0
      if (g == 0) begin : gDelim0
        assign evtRaw[SL_DELIM] = mode4x ? |delimErr : delimErr[0];
      end else begin : gDelimN
        assign evtRaw[SL_DELIM+g] = !mode4x && delimErr[g];
      end
      assign evtCode[SL_DELIM+g] = CODE_DELIM;
      assign evtSrc[SL_DELIM+g] = SRC_PORT[g];
      assign evtRaw[SL_ACK+g] = ackIdErr[g];
      assign evtCode[SL_ACK+g] = CODE_ACKNOWLEDGE_IDENTIFIER;
      assign evtSrc[SL_ACK+g] = SRC_PORT[g];
    end
    // group-based enable gating
    for (g = 0; g < SLOT_CNT; g++) begin : gGate
      assign evt[g] = evtRaw[g] && reportOn(evtCode[g], ctrl_q);
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // pending store and log arbitration
  logic [7:0] pcode_q [SLOT_CNT];
  logic [5:0] psrc_q [SLOT_CNT];
  logic [SLOT_W-1:0] grant_q;
  logic logValid_q;
  logic [5:0] logSource_q;
  logic [7:0] logCode_q;
  logic taken;
  logic anyPend;
  logic [SLOT_W-1:0] pick;

  assign taken = logValid_q && logAccept;

  // a new event in the clearing cycle keeps the slot pending
  always_ff @(posedge clk) begin
    if (rst) begin
      pend_q <= '0;
      for (int i = 0; i < SLOT_CNT; i++) begin
        pcode_q[i] <= CODE_NONE;
        psrc_q[i] <= SRC_CFG;
      end
    end else begin
      for (int i = 0; i < SLOT_CNT; i++) begin
        if (evt[i]) begin
          pend_q[i] <= 1'b1;
          pcode_q[i] <= evtCode[i];
          psrc_q[i] <= evtSrc[i];
        end else if (taken && grant_q == SLOT_W'(i)) begin
          pend_q[i] <= 1'b0;
        end
      end
    end
  end

  // fixed priority, lowest slot first; config errors win under storms
  always_comb begin
    anyPend = |pend_q;
    pick = '0;
    for (int i = SLOT_CNT - 1; i >= 0; i--) begin
      if (pend_q[i]) begin
        pick = SLOT_W'(i);
      end
    end
  end

  // one entry offered at a time, held until accepted
  always_ff @(posedge clk) begin
    if (rst) begin
      logValid_q <= 1'b0;
      logSource_q <= SRC_CFG;
      logCode_q <= CODE_NONE;
      grant_q <= '0;
    end else if (taken) begin
      logValid_q <= 1'b0;
    end else if (!logValid_q && anyPend) begin
      logValid_q <= 1'b1;
      grant_q <= pick;
      logSource_q <= psrc_q[pick];
      logCode_q <= pcode_q[pick];
    end
  end
  assign logValid = logValid_q;
  assign logSource = logSource_q;
  assign logCode = logCode_q;

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  AST_RT_NOROUTE: assert property (
    regWr && regAddr == REG_RT_DATA && !dom && routeCheck(wVal, 1'b0) != CODE_NONE
    |=> routeTbl_q[$past(idx)] == VAL_NO_ROUTE)
    else $error("bad route write not replaced by no-route");

  AST_DOM_MASK: assert property (
    regWr && regAddr == REG_RT_DATA && dom && wVal >= VAL_MASK_BASE && wVal <= VAL_MASK_LAST && ctrl_q[CTRL_CFG_EN]
    |=> pend_q[SL_CFG] && pcode_q[SL_CFG] == CODE_MASK_CFG)
    else $error("mask into domain table not flagged 0x50");

  AST_TRACE_PORT: assert property (
    regWr && regAddr == REG_TRACE && !portOk(wVal) && ctrl_q[CTRL_CFG_EN]
    |=> pcode_q[SL_CFG] == CODE_PORT_CFG && $stable(trace_q))
    else $error("invalid trace port not flagged or stored");

  AST_READ_FAIL: assert property (
    regRd && regAddr == REG_RT_DATA && routeCheck(entryVal, dom) != CODE_NONE
    |=> regRdata_q[7:0] == VAL_READ_FAIL)
    else $error("illegal route read not all ones");

  AST_CFG_GATE: assert property (
    !ctrl_q[CTRL_CFG_EN] && !pend_q[SL_CFG] ##1 !ctrl_q[CTRL_CFG_EN] |-> !pend_q[SL_CFG])
    else $error("config error pending while reporting off");

  AST_SYNC_LANE0: assert property (
    rise[0] && ctrl_q[CTRL_QUAD_EN] |=> pend_q[SL_SYNC] && pcode_q[SL_SYNC] == CODE_SYNC_LANE0)
    else $error("lane 0 sync loss not logged as 0x60");

  AST_DELIM_4X: assert property (
    mode4x && (|delimErr) && ctrl_q[CTRL_PORT_EN] |=> pend_q[SL_DELIM] && psrc_q[SL_DELIM] == SRC_PORT[0])
    else $error("4x delimiter error not on port 0");

  AST_ACK: assert property (
    ackIdErr[1] && ctrl_q[CTRL_PORT_EN] |=> pend_q[SL_ACK+1] && pcode_q[SL_ACK+1] == CODE_ACKNOWLEDGE_IDENTIFIER)
    else $error("ack id error not logged as 0x72");

  AST_HOLD: assert property (
    logValid_q && !logAccept |=> logValid_q && $stable(logCode_q) && $stable(logSource_q))
    else $error("offered entry dropped before acceptance");

  AST_RD_ONCE: assert property (
    !regRd |=> regRdata_q == '0)
    else $error("read data outside its cycle");

  COV_CFG_LOG: cover property (logValid_q && logAccept && logCode_q == CODE_BIT_CFG);
  COV_ALIGN: cover property (evt[SL_ALIGN]);
  COV_STALL: cover property (logValid_q && !logAccept ##1 logValid_q && logAccept);

endmodule
`default_nettype wire

/* File: cled_pkg.sv */
`default_nettype none
package cled_pkg;
  // bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  // device geometry
  localparam int PORT_CNT = 12;
  localparam int MASK_CNT = 8;
  localparam int MASK_IDX_W = 3;
  localparam int LANE_CNT = 4;
  localparam int ENTRY_CNT = 16;
  localparam int ENTRY_IDX_W = 4;
  localparam int SYNC_CNT = 5;
  // pending slots: config, lane sync, alignment, char, delimiter, ack id
  localparam int SLOT_CNT = 18;
  localparam int SLOT_W = 5;
  localparam int SL_CFG = 0;
  localparam int SL_SYNC = 1;
  localparam int SL_ALIGN = 5;
  localparam int SL_CHAR = 6;
  localparam int SL_DELIM = 10;
  localparam int SL_ACK = 14;
  // register offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_RT_INDEX = 8'h04;
  localparam logic [7:0] REG_RT_DATA = 8'h08;
  localparam logic [7:0] REG_MC_MASK_PORT = 8'h0C;
  localparam logic [7:0] REG_MC_ASSOC_SEL = 8'h10;
  localparam logic [7:0] REG_MC_ASSOC_OP = 8'h14;
  localparam logic [7:0] REG_MC_VEC = 8'h18;
  localparam logic [7:0] REG_IN_PORTS = 8'h1C;
  localparam logic [7:0] REG_OUT_PORTS = 8'h20;
  localparam logic [7:0] REG_TRACE = 8'h24;
  localparam logic [7:0] REG_STATUS = 8'h28;
  // field positions
  localparam int CTRL_CFG_EN = 0;
  localparam int CTRL_QUAD_EN = 1;
  localparam int CTRL_PORT_EN = 2;
  localparam int CTRL_MODE4X = 3;
  localparam int CTRL_W = 4;
  localparam int RT_DOM_BIT = 4;
  localparam int MP_PORT_LSB = 8;
  localparam int MP_ADD_BIT = 16;
  localparam int OP_DOM_BIT = 8;
  localparam int STAT_LANE_LSB = 24;
  localparam logic [1:0] OP_WRITE_VERIFY = 2'h1;
  // route table values
  localparam logic [7:0] VAL_MASK_BASE = 8'h40;
  localparam logic [7:0] VAL_MASK_LAST = 8'h7F;
  localparam logic [7:0] VAL_NO_ROUTE = 8'hDE;
  localparam logic [7:0] VAL_FORCE_LOCAL = 8'hDD;
  localparam logic [7:0] VAL_READ_FAIL = 8'hFF;
  // error groups and codes
  localparam logic [3:0] GRP_CFG = 4'h5;
  localparam logic [3:0] GRP_SERDES = 4'h6;
  localparam logic [3:0] GRP_LINK = 4'h7;
  localparam logic [7:0] CODE_NONE = 8'h00;
  localparam logic [7:0] CODE_MASK_CFG = 8'h50;
  localparam logic [7:0] CODE_PORT_CFG = 8'h53;
  localparam logic [7:0] CODE_FORCE_LOCAL = 8'h54;
  localparam logic [7:0] CODE_RT_READ = 8'h55;
  localparam logic [7:0] CODE_BIT_CFG = 8'h56;
  localparam logic [7:0] CODE_SYNC_LANE0 = 8'h60;
  localparam logic [7:0] CODE_ALIGN = 8'h64;
  localparam logic [7:0] CODE_CHAR = 8'h70;
  localparam logic [7:0] CODE_DELIM = 8'h71;
  localparam logic [7:0] CODE_ACKNOWLEDGE_IDENTIFIER = 8'h72;
  // error sources
  localparam logic [5:0] SRC_CFG = 6'h00;
  localparam logic [5:0] SRC_PORT [LANE_CNT] = '{6'h2A, 6'h29, 6'h34, 6'h33};
endpackage
`default_nettype wire

/* File: cled_log_model.sv */
`default_nettype none
module cled_log_model
  import cled_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic logValid,
  input wire logic [7:0] stallCycles,
  output logic logAccept
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] waitCnt_q; // cycles spent looking at the offered entry
  ////////////////////////////////////////////////////////////
  // single shared log: one entry taken at a time, after a commanded stall
  // accept is registered, so a held entry always sees at least one cycle of wait
  always_ff @(posedge clk) begin
    if (rst) begin
      waitCnt_q <= 8'h00;
      logAccept <= 1'b0;
    end else if (logValid && !logAccept) begin
      // slow arbiter: the device must keep offering meanwhile
      if (waitCnt_q >= stallCycles) begin
        logAccept <= 1'b1;
        waitCnt_q <= 8'h00;
      end else begin
        waitCnt_q <= waitCnt_q + 8'h01;
      end
    end else begin
      // accept lasts one cycle only
      logAccept <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* File: testbench.sv */
`default_nettype none
module testbench
  import cled_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, rst, regWr, regRd, alignLost, logAccept, logValid;
  logic [ADDR_W-1:0] regAddr;
  logic [DATA_W-1:0] regWdata, regRdata, d;
  logic [LANE_CNT-1:0] laneSyncLost, charErr, delimErr, ackIdErr;
  logic [5:0] logSource;
  logic [7:0] logCode, stallCycles, v;
  logic [15:0] rnd; // lfsr state
  logic [13:0] seen [$]; // entries taken by the log model
  int n_fail, total_checks;
  logic [7:0] rtVal [4] = '{8'h48, 8'h0C, VAL_FORCE_LOCAL, 8'h05};
  logic [7:0] rtCode [4] = '{CODE_MASK_CFG, CODE_PORT_CFG, CODE_FORCE_LOCAL, CODE_NONE};
  cled_config_link_error_detect i_cled_config_link_error_detect (.clk(clk), .rst(rst), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .laneSyncLost(laneSyncLost),
    .alignLost(alignLost), .charErr(charErr), .delimErr(delimErr), .ackIdErr(ackIdErr), .logAccept(logAccept),
    .logValid(logValid), .logSource(logSource), .logCode(logCode));
  cled_log_model i_cled_log_model (.clk(clk), .rst(rst), .logValid(logValid), .stallCycles(stallCycles),
    .logAccept(logAccept));
  ////////////////////////////////////////////////////////////
  // expectations
  function automatic logic [15:0] lfsrNext(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [13:0] cfgE(input logic [7:0] c);
    return {SRC_CFG, c};
  endfunction
  function automatic logic [13:0] laneE(input int i, input logic [7:0] c);
    return {SRC_PORT[i], c};
  endfunction
  ////////////////////////////////////////////////////////////
  // checks and bus cycles
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] dat);
    @(posedge clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= dat;
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  // data stands only in the cycle after the strobe, zero after it
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    #1;
    check("regRdata", exp, regRdata);
    @(posedge clk);
    #1;
    check("regRdata idle", 32'h0, regRdata);
  endtask
  task automatic pulse(input int kind, input logic [3:0] m);
    @(posedge clk);
    case (kind)
      0: charErr <= m;
      1: delimErr <= m;
      default: ackIdErr <= m;
    endcase
    @(posedge clk);
    charErr <= 4'h0;
    delimErr <= 4'h0;
    ackIdErr <= 4'h0;
  endtask
  // bounded wait for the next logged entry; mask hides unknown fields
  task automatic expectEntry(input logic [13:0] e, input logic [13:0] m = 14'h3FFF);
    int n;
    n = 0;
    while (seen.size() == 0 && n < 100) begin
      @(posedge clk);
      n++;
    end
    if (seen.size() == 0) check("log entry", {18'h0, e}, 32'hFFFFFFFF);
    else check("log entry", {18'h0, e & m}, {18'h0, seen.pop_front() & m});
  endtask
  task automatic expectNone();
    repeat (20) @(posedge clk);
    check("log idle", 32'h0, seen.size());
  endtask
  task automatic final_report();
    $display("checks %0d n_fail %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  // clock, capture, watchdog
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    if (logValid === 1'b1 && logAccept === 1'b1) begin
      seen.push_back({logSource, logCode});
    end
  end
  initial begin
    repeat (30000) @(posedge clk);
    n_fail++;
    final_report();
  end
  ////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    {rst, regWr, regRd, alignLost} = 4'hF;
    {regWr, regRd, alignLost} = 3'h0;
    {regAddr, regWdata, laneSyncLost, charErr, delimErr, ackIdErr, stallCycles} = '0;
    rnd = 16'h4836;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rd(REG_CTRL, 32'h0);
    rd(REG_RT_DATA, {24'h0, VAL_NO_ROUTE});
    rd(REG_STATUS, 32'h0);
    rd(8'h3C, 32'h0);
    wr(REG_TRACE, 32'h0C);
    expectNone();
    wr(REG_CTRL, 32'h1);
    wr(8'h3C, 32'hF);
    rd(REG_CTRL, 32'h1);
    wr(REG_TRACE, 32'h0C);
    expectEntry(cfgE(CODE_PORT_CFG));
    wr(REG_TRACE, 32'h0B);
    expectNone();
    // corner route values first, then random legal ports and masks
    for (int i = 0; i < 8; i++) begin
      rnd = lfsrNext(rnd);
      v = (i < 4) ? rtVal[i] : (rnd[0] ? {4'h0, rnd[7:4] % 4'hC} : VAL_MASK_BASE + {5'h0, rnd[3:1]});
      wr(REG_RT_INDEX, i);
      wr(REG_RT_DATA, {24'h0, v});
      if (i < 3) expectEntry(cfgE(rtCode[i]));
      else expectNone();
      rd(REG_RT_DATA, {24'h0, (i < 3) ? VAL_NO_ROUTE : v});
    end
    wr(REG_RT_INDEX, 32'h10);
    wr(REG_RT_DATA, 32'h41);
    expectEntry(cfgE(CODE_MASK_CFG));
    wr(REG_MC_MASK_PORT, 32'h10008);
    expectEntry(cfgE(CODE_MASK_CFG));
    wr(REG_MC_MASK_PORT, 32'h10C00);
    expectEntry(cfgE(CODE_PORT_CFG));
    wr(REG_MC_ASSOC_SEL, 32'h2);
    wr(REG_MC_VEC, 32'h1005);
    expectEntry(cfgE(CODE_BIT_CFG));
    rd(REG_MC_VEC, 32'h005);
    wr(REG_MC_ASSOC_SEL, 32'h9);
    expectEntry(cfgE(CODE_MASK_CFG));
    rd(REG_MC_VEC, 32'h0);
    expectEntry(cfgE(CODE_MASK_CFG));
    wr(REG_MC_ASSOC_OP, 32'h101);
    expectEntry(cfgE(CODE_MASK_CFG));
    // random selections with a stray high bit, and without
    for (int i = 0; i < 4; i++) begin
      rnd = lfsrNext(rnd);
      d = {rnd, lfsrNext(rnd)} | ((i < 2) ? 32'h80000000 : 32'h0);
      d = (i < 2) ? d : d & 32'hFFF;
      wr(i[0] ? REG_OUT_PORTS : REG_IN_PORTS, d);
      if (i < 2) expectEntry(cfgE(CODE_BIT_CFG));
      else expectNone();
      rd(i[0] ? REG_OUT_PORTS : REG_IN_PORTS, d & 32'hFFF);
    end
    // link layer: off, then per lane in 1x, then folding in 4x
    wr(REG_CTRL, 32'h2);
    pulse(0, 4'h1);
    expectNone();
    wr(REG_CTRL, 32'h4);
    for (int i = 0; i < 4; i++) begin
      pulse(0, 4'h1 << i);
      expectEntry(laneE(i, CODE_CHAR));
      pulse(1, 4'h1 << i);
      expectEntry(laneE(i, CODE_DELIM));
      pulse(2, 4'h1 << i);
      expectEntry(laneE(i, CODE_ACKNOWLEDGE_IDENTIFIER));
    end
    wr(REG_CTRL, 32'hC);
    pulse(1, 4'h8);
    expectEntry(laneE(0, CODE_DELIM));
    pulse(0, 4'h8);
    expectEntry(laneE(3, CODE_CHAR));
    // serdes: gated off, then each lane and alignment
    laneSyncLost <= 4'h1;
    expectNone();
    rd(REG_STATUS, 32'h01000000);
    laneSyncLost <= 4'h0;
    wr(REG_CTRL, 32'hA);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      laneSyncLost <= 4'h1 << i;
      expectEntry(laneE(i, CODE_SYNC_LANE0 + i[7:0]));
      laneSyncLost <= 4'h0;
      repeat (8) @(posedge clk);
    end
    alignLost <= 1'b1;
    expectEntry({6'h0, CODE_ALIGN}, 14'h00FF);
    alignLost <= 1'b0;
    wr(REG_CTRL, 32'h2);
    alignLost <= 1'b1;
    expectNone();
    alignLost <= 1'b0;
    // simultaneous sources against a stalling log
    wr(REG_CTRL, 32'h5);
    stallCycles <= 8'h05;
    fork
      wr(REG_TRACE, 32'h0C);
      pulse(0, 4'hF);
    join
    expectEntry(cfgE(CODE_PORT_CFG));
    for (int i = 0; i < 4; i++) expectEntry(laneE(i, CODE_CHAR));
    for (int k = 0; k < 6; k++) begin
      rnd = lfsrNext(rnd);
      stallCycles <= {5'h0, rnd[2:0]};
      pulse(2, rnd[7:4] | 4'h1);
      for (int i = 0; i < 4; i++) begin
        if (i == 0 || rnd[4 + i]) expectEntry(laneE(i, CODE_ACKNOWLEDGE_IDENTIFIER));
      end
    end
    expectNone();
    final_report();
  end
endmodule
`default_nettype wire
